// ===== tb/cache_geometry_id_regs_checker.sv
`timescale 1ns/1ps
module cache_geometry_id_regs_checker
  import cache_geometry_pkg::*;
#(
  parameter int data_cache_kb = default_cache_kb,
  parameter int instr_cache_kb = default_cache_kb
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset
  input wire logic cp_valid, // request
  input wire logic cp_read, // read not write
  input wire logic [3:0] cp_coproc, // coprocessor
  input wire logic [2:0] cp_opc1, // first opcode
  input wire logic [3:0] cp_crn, // primary reg
  input wire logic [3:0] cp_crm, // secondary reg
  input wire logic [2:0] cp_opc2, // second opcode
  input wire logic cp_privileged, // privileged mode
  input wire logic instruction_not_data_select, // chosen cache
  input wire logic cp_ready, // idle
  input wire logic cp_done, // answer pulse
  input wire logic cp_undefined, // refused
  input wire logic [31:0] cp_rdata // read data
);
  // accepted request and its decode
  logic take;
  logic enc;
  logic rd_hit;
  assign take = cp_valid && cp_ready;
  assign enc = cp_coproc == cp_number && cp_opc1 == id_opc1 && cp_crn == id_crn;
  assign rd_hit = take && enc && cp_crm == id_crm && cp_read && cp_privileged;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  answer_time_a: assert property (take |=> !cp_ready ##1 cp_done)
    else $error("answer not two cycles after take");
  no_write_through_a: assert property (cp_done |-> !cp_rdata[31])
    else $error("top bit of answer set");
  size_flags_a: assert property (rd_hit && cp_opc2 == size_id_opc2 |-> ##2
    cp_rdata[31:28] == ($past(instruction_not_data_select, 2) ? 4'h2 : 4'h7))
    else $error("size word top nibble wrong");
  set_count_a: assert property (rd_hit && cp_opc2 == size_id_opc2 |-> ##2
    cp_rdata[27:13] == ($past(instruction_not_data_select, 2) ?
    15'(instr_cache_kb * 16 - 1) : 15'(data_cache_kb * 8 - 1)))
    else $error("set count wrong");
  assoc_line_a: assert property (rd_hit && cp_opc2 == 3'h0 && !instruction_not_data_select
    |-> ##2 cp_rdata[12:0] == 13'h0019 && !cp_undefined)
    else $error("data associativity or line length wrong");
  level_word_a: assert property (rd_hit && cp_opc2 == 3'h1 |->
    ##2 cp_rdata == 32'h0920_0003 && !cp_undefined)
    else $error("level word wrong");
  unpriv_refused_a: assert property (take && !cp_privileged |->
    ##2 cp_undefined && cp_rdata == 32'h0)
    else $error("unprivileged access not refused");
  write_ignored_a: assert property (take && enc && cp_crm == 4'h0 && !cp_read &&
    cp_privileged && cp_opc2 < 3'h2 |-> ##2 !cp_undefined && cp_rdata == 32'h0)
    else $error("write not ignored");
endmodule
bind cache_geometry_id_regs cache_geometry_id_regs_checker #(.data_cache_kb(data_cache_kb),
  .instr_cache_kb(instr_cache_kb)) chk_u (.clk, .rst_n, .cp_valid, .cp_read, .cp_coproc,
  .cp_opc1, .cp_crn, .cp_crm, .cp_opc2, .cp_privileged, .instruction_not_data_select,
  .cp_ready, .cp_done, .cp_undefined, .cp_rdata);

// ===== tb/cache_geometry_id_regs_tb.sv
`timescale 1ns/1ps
module cache_geometry_id_regs_tb;
  import cache_geometry_pkg::*;
  localparam int dkb = 4; // smallest data size
  localparam int ikb = 64; // largest instruction size
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cp_valid = 1'b0, cp_read = 1'b0, cp_privileged = 1'b0, cp_secure = 1'b0, sel = 1'b0;
  logic [3:0] cp_coproc = 4'h0, cp_crn = 4'h0, cp_crm = 4'h0;
  logic [2:0] cp_opc1 = 3'h0, cp_opc2 = 3'h0;
  logic cp_ready, cp_done, cp_undefined, config_error;
  logic [31:0] cp_rdata;
  logic [31:0] seed = 32'h78046400;
  int failures = 0, n_checks = 0;
  // 4 ns period
  always #2 clk = ~clk;
  cache_geometry_id_regs #(.data_cache_kb(dkb), .instr_cache_kb(ikb)) dut_u (.clk, .rst_n,
    .cp_valid, .cp_read, .cp_coproc, .cp_opc1, .cp_crn, .cp_crm, .cp_opc2, .cp_privileged,
    .cp_secure, .instruction_not_data_select(sel), .cp_ready, .cp_done, .cp_undefined,
    .cp_rdata, .config_error);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected refusal flag above read data
  function automatic logic [32:0] expect_ans(input logic hit, pv, rd, s, input logic [2:0] o2);
    if (!hit || !pv || o2 > 3'h1) return {1'b1, 32'h0};
    if (!rd) return 33'h0;
    if (o2 == 3'h1) return {1'b0, 32'h0920_0003};
    if (s) return {5'h02, 15'(ikb * 16 - 1), 10'h001, 3'h1};
    return {5'h07, 15'(dkb * 8 - 1), 10'h003, 3'h1};
  endfunction
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // single status flag against its expected level
  task automatic chk_flag(input logic got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [32:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t answer %h expected %h", $time, got, exp);
    end
  endtask
  // one access; idle front end takes it at the next edge
  task automatic run(input logic [3:0] cop, input logic [2:0] o1, input logic [3:0] n, m,
    input logic [2:0] o2, input logic rd, pv, s, sec);
    int i;
    @(posedge clk);
    cp_valid <= 1'b1;
    cp_coproc <= cop;
    cp_opc1 <= o1;
    cp_crn <= n;
    cp_crm <= m;
    cp_opc2 <= o2;
    cp_read <= rd;
    cp_privileged <= pv;
    sel <= s;
    cp_secure <= sec;
    @(posedge clk);
    cp_valid <= 1'b0;
    // bounded wait, the answer pulse is checked once settled
    for (i = 0; i < 6 && cp_done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    // a missing answer is a mismatch and ends the run at once
    if (cp_done !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t no answer pulse", $time);
      close_out();
    end else begin
      chk({cp_undefined, cp_rdata},
        expect_ans(cop == 4'hf && o1 == 3'h1 && n == 4'h0 && m == 4'h0, pv, rd, s, o2));
      chk_flag(cp_ready, 1'b1);
    end
  endtask
  // corners first, then random traffic biased towards hits
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_flag(config_error, 1'b0);
    run(4'hf, 3'h1, 4'h0, 4'h0, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    run(4'hf, 3'h1, 4'h0, 4'h0, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    run(4'hf, 3'h1, 4'h0, 4'h0, 3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
    run(4'hf, 3'h1, 4'h0, 4'h0, 3'h1, 1'b1, 1'b1, 1'b1, 1'b1);
    run(4'hf, 3'h1, 4'h0, 4'h0, 3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    run(4'hf, 3'h1, 4'h0, 4'h0, 3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    run(4'he, 3'h1, 4'h0, 4'h0, 3'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    for (int k = 0; k < 80; k++) begin
      seed = lfsr(seed);
      run(seed[3:0] == 4'h0 ? seed[7:4] : 4'hf, seed[8] & seed[9] ? seed[12:10] : 3'h1,
        seed[13] & seed[14] ? seed[19:16] : 4'h0, seed[20] & seed[21] ? 4'h3 : 4'h0,
        seed[22] & seed[23] ? seed[26:24] : {2'h0, seed[27]}, seed[28] | seed[29],
        seed[30] | seed[0], seed[31], seed[5]);
    end
    close_out();
  end
endmodule

// ===== verilog/cache_geometry_id_regs.sv
`timescale 1ns/1ps
module cache_geometry_id_regs
  import cache_geometry_pkg::*;
#(
  parameter int data_cache_kb = default_cache_kb, // 4, 8, 16, 32 or 64
  parameter int instr_cache_kb = default_cache_kb // 4, 8, 16, 32 or 64
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic cp_valid, // coprocessor access request
  input wire logic cp_read, // one for read, zero for write
  input wire logic [3:0] cp_coproc, // coprocessor number
  input wire logic [2:0] cp_opc1, // first opcode
  input wire logic [3:0] cp_crn, // primary register
  input wire logic [3:0] cp_crm, // secondary register
  input wire logic [2:0] cp_opc2, // second opcode
  input wire logic cp_privileged, // core in privileged mode
  input wire logic cp_secure, // core in secure state
  input wire logic instruction_not_data_select, // selection register bit 0
  output logic cp_ready, // front end can take a request
  output logic cp_done, // answer pulse
  output logic cp_undefined, // access refused, raise undefined
  output logic [31:0] cp_rdata, // read data
  output logic config_error // cache size parameter not legal
);

  typedef enum logic [1:0] {
    idle_st,
    answer_st
  } front_state_type;

  typedef enum logic [1:0] {
    target_none,
    target_size,
    target_level
  } target_type;

  front_state_type state;
  front_state_type next_state;
  target_type captured_target;
  logic captured_write;
  logic captured_priv;
  logic captured_select;
  logic take;
  logic [31:0] next_rdata;
  logic next_undefined;

  id_word_if ids ();

  // decode of an access address into one of our two registers
  function automatic target_type decode_target(
    input logic [3:0] coproc,
    input logic [2:0] opc1,
    input logic [3:0] crn,
    input logic [3:0] crm,
    input logic [2:0] opc2
  );
    target_type t;
    t = target_none;
    if (coproc == cp_number && opc1 == id_opc1 && crn == id_crn && crm == id_crm) begin
      if (opc2 == size_id_opc2) begin
        t = target_size;
      end else if (opc2 == level_id_opc2) begin
        t = target_level;
      end
    end
    return t;
  endfunction

  // a build with an unsupported size is flagged rather than silently mis-encoded
  localparam logic sizes_ok = size_legal(data_cache_kb) && size_legal(instr_cache_kb);

  // value builders; the size word follows the captured selection
  size_word_builder #(
    .data_cache_kb(data_cache_kb),
    .instr_cache_kb(instr_cache_kb)
  ) size_builder (
    .ids(ids)
  );

  level_word_builder level_builder (
    .ids(ids)
  );

  // only one request in flight; a request waits during the answer cycle, and is taken again while the answer pulse is out
  assign cp_ready = (state == idle_st);
  assign take = cp_valid && cp_ready;

  // state sequencing: idle, then one answer cycle
  always_comb begin
    next_state = state;
    case (state)
      idle_st: begin
        if (take) begin
          next_state = answer_st;
        end
      end
      answer_st: begin
        next_state = idle_st;
      end
      default: begin
        next_state = idle_st;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= idle_st;
    end else begin
      state <= next_state;
    end
  end

  // request capture; selection sampled with the request so a later
  // change of the selection register cannot tear the answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      captured_target <= target_none;
      captured_write <= 1'b0;
      captured_priv <= 1'b0;
      captured_select <= 1'b0;
    end else if (take) begin
      captured_target <= decode_target(cp_coproc, cp_opc1, cp_crn, cp_crm, cp_opc2);
      captured_write <= !cp_read;
      captured_priv <= cp_privileged;
      captured_select <= instruction_not_data_select;
    end
  end

  assign ids.select_instruction = captured_select;

  // answer formation; security state plays no part since both registers
  // have a single shared copy
  always_comb begin
    next_rdata = rdata_reset;
    next_undefined = 1'b0;
    case (captured_target)
      target_size: begin
        if (!captured_priv) begin
          next_undefined = 1'b1;
        end else if (!captured_write) begin
          next_rdata = ids.size_word;
        end
      end
      target_level: begin
        if (!captured_priv) begin
          next_undefined = 1'b1;
        end else if (!captured_write) begin
          next_rdata = ids.level_word;
        end
      end
      default: begin
        next_undefined = 1'b1; // address not ours
      end
    endcase
    // privileged writes to identification words complete but change nothing
    if (captured_write) begin
      next_rdata = rdata_reset;
    end
  end

  // answer registers: data held until the next answer, strobes one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_rdata <= rdata_reset;
    end else if (state == answer_st) begin
      cp_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_done <= 1'b0;
      cp_undefined <= 1'b0;
    end else begin
      cp_done <= (state == answer_st);
      cp_undefined <= (state == answer_st) && next_undefined;
    end
  end

  // configuration flag; constant, but registered so it is driven from reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_error <= 1'b0;
    end else begin
      config_error <= !sizes_ok;
    end
  end

  // secure state has no effect here; kept on the port for a uniform access bus
  logic unused_secure;
  assign unused_secure = cp_secure;

endmodule

// ===== verilog/cache_geometry_pkg.sv
package cache_geometry_pkg;

  // coprocessor encoding of the two identification registers
  localparam logic [3:0] cp_number = 4'hf;
  localparam logic [2:0] id_opc1 = 3'h1;
  localparam logic [3:0] id_crn = 4'h0;
  localparam logic [3:0] id_crm = 4'h0;
  localparam logic [2:0] size_id_opc2 = 3'h0;
  localparam logic [2:0] level_id_opc2 = 3'h1;

  // cache_size_identification field positions
  localparam int write_through_bit = 31;
  localparam int write_back_bit = 30;
  localparam int read_allocate_bit = 29;
  localparam int write_allocate_bit = 28;
  localparam int set_count_hi = 27;
  localparam int set_count_lo = 13;
  localparam int assoc_hi = 12;
  localparam int assoc_lo = 3;
  localparam int line_length_hi = 2;
  localparam int line_length_lo = 0;

  // cache_size_identification field values
  localparam logic [3:0] instr_top_nibble = 4'h2;
  localparam logic [3:0] data_top_nibble = 4'h7;
  localparam logic [9:0] data_assoc = 10'h003;
  localparam logic [9:0] instr_assoc = 10'h001;
  localparam logic [2:0] line_length_code = 3'h1;
  localparam int line_bytes = 32;
  localparam int data_ways = 4;
  localparam int instr_ways = 2;

  // cache_level_identification field values, high field to low field
  localparam logic [1:0] level_reserved = 2'h0;
  localparam logic [2:0] unification_level_uniproc = 3'h1;
  localparam logic [2:0] coherency_level = 3'h1;
  localparam logic [2:0] unification_level_inner_shared = 3'h1;
  localparam logic [2:0] no_cache_code = 3'h0;
  localparam logic [2:0] split_cache_code = 3'h3;
  localparam int absent_levels = 6;

  // reset value of the read data answer register, and the default cache size
  localparam logic [31:0] rdata_reset = 32'h0000_0000;
  localparam int default_cache_kb = 32;

  // true for the cache sizes the build supports
  function automatic logic size_legal(input int kb);
    return (kb == 4) || (kb == 8) || (kb == 16) || (kb == 32) || (kb == 64);
  endfunction

  // sets minus one for a given size and number of ways
  function automatic logic [14:0] sets_minus_one(input int kb, input int ways);
    int sets;
    sets = (kb * 1024) / (ways * line_bytes);
    return 15'(sets - 1);
  endfunction

endpackage

// ===== verilog/id_word_if.sv
`timescale 1ns/1ps
// words flowing between the register front end and its value builders
interface id_word_if;
  logic select_instruction; // chosen cache, one for instruction
  logic [31:0] size_word; // cache_size_identification content
  logic [31:0] level_word; // cache_level_identification content

  modport front (output select_instruction, input size_word, input level_word);
  modport size_src (input select_instruction, output size_word);
  modport level_src (output level_word);
endinterface

// ===== verilog/level_word_builder.sv
`timescale 1ns/1ps
module level_word_builder
  import cache_geometry_pkg::*;
(
  id_word_if.level_src ids // level word out
);

  // constant hierarchy: one split level, nothing beyond it
  assign ids.level_word = {
    level_reserved,
    unification_level_uniproc,
    coherency_level,
    unification_level_inner_shared,
    {absent_levels{no_cache_code}},
    split_cache_code
  };

endmodule

// ===== verilog/size_word_builder.sv
`timescale 1ns/1ps
module size_word_builder
  import cache_geometry_pkg::*;
#(
  parameter int data_cache_kb = default_cache_kb,
  parameter int instr_cache_kb = default_cache_kb
) (
  id_word_if.size_src ids // selection in, size word out
);

  localparam logic [14:0] data_sets = sets_minus_one(data_cache_kb, data_ways);
  localparam logic [14:0] instr_sets = sets_minus_one(instr_cache_kb, instr_ways);

  // pure decode of the selection; no state, so a new selection shows at once
  always_comb begin
    ids.size_word = 32'h0000_0000;
    if (ids.select_instruction) begin
      ids.size_word[31:28] = instr_top_nibble;
      ids.size_word[set_count_hi:set_count_lo] = instr_sets;
      ids.size_word[assoc_hi:assoc_lo] = instr_assoc;
    end else begin
      ids.size_word[31:28] = data_top_nibble;
      ids.size_word[set_count_hi:set_count_lo] = data_sets;
      ids.size_word[assoc_hi:assoc_lo] = data_assoc;
    end
    ids.size_word[write_through_bit] = 1'b0;
    ids.size_word[line_length_hi:line_length_lo] = line_length_code;
  end

endmodule
